/* verilog/arl_relay_out.sv */
// Alarm relay output stage with analog retransmission scaling.
// Assumes alarm levels and display value come from logic on ref_clk;
// buttons and remote input are raw pins. Latching and delays are upstream.
//
// Summary of operation
// - Each relay has an idle polarity, open by default, and flips when in alarm.
// - With acknowledge enabled, an acknowledge during alarm releases the relay at once; off by default.
// - The release works the same whether the upstream alarm latches or resets itself.
// - Acknowledge comes from the front button, and optionally a second button or remote input.
// - In OR mode, the default, a relay is active when any assigned alarm is active.
// - In AND mode a relay is active only while all assigned alarms are active.
// - Each analog output is 16 bits, type 4-20 mA, 0-1 V or 0-10 V, 4-20 mA by default.
// - The type choice is not offered when only current-loop hardware is fitted.
// - A low display value, default 0, maps to the bottom of the output range.
// - A high display value, default 1000, maps to the top of the output range.
// - A second output with its own settings exists only with the dual option.
// - Each alarm is assigned per relay by an on/off bit, off by default.
// - Hysteresis and delays keep applying in latching mode, upstream of this block.
`timescale 1ns/1ps
`default_nettype none
module arl_relay_out
#(
  parameter bit CHOICE_FITTED = 1'b1,
  parameter bit DUAL_FITTED = 1'b1
)
(
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic [7:0] alarm_active,
  input wire logic [31:0] disp_value,
  input wire logic ack_front_pin,
  input wire logic ack_alt_pin,
  input wire logic ack_remote_pin,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output logic irq,
  output logic [6:0] relay_drive,
  output logic [15:0] ao_code_1,
  output logic [15:0] ao_code_2,
  output logic [1:0] retransmit_type_select_1,
  output logic [1:0] retransmit_type_select_2
);
  typedef struct packed {
    // Configuration
    logic [6:0] pol;
    logic [6:0] ack_en;
    logic [6:0] and_mode;
    logic [6:0][7:0] alloc;
    logic [1:0] ack_src;
    logic [1:0][1:0] ao_type;
    logic [1:0][31:0] ao_lo;
    logic [1:0][31:0] ao_hi;
    // Relay state and interrupts
    logic [6:0] hold;
    logic [6:0] act_prev;
    logic [6:0] relay;
    logic [7:0] int_stat;
    logic [7:0] int_en;
    logic irq;
    // Read data
    logic [31:0] rdata;
    // Pin synchroniser and edge
    logic [2:0] pin_s1;
    logic [2:0] pin_s2;
    logic [2:0] pin_prev;
  } arl_top_t;

  arl_top_t r_ff;
  arl_top_t nxt_r;
  // Filled in the next-state process
  logic [6:0] act;
  logic [2:0] pin_rise;
  logic ack_evt;
  // Codes from the scalers' own flops
  logic [15:0] code_1;
  logic [15:0] code_2;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  // Empty allocation never activates, in either mode
  function automatic logic combine(input logic [7:0] mask, input logic [7:0] al, input logic and_m);
    logic res;
    res = 1'b0;
    if (mask != 8'h00)
    begin
      if (and_m)
        res = &(al | ~mask);
      else
        res = |(al & mask);
    end
    return res;
  endfunction

  // Illegal code or current-only hardware falls back to 4-20 mA
  function automatic logic [1:0] fix_type(input logic [1:0] t);
    logic [1:0] res;
    res = t;
    if (!CHOICE_FITTED || t == 2'b11)
      res = arl_pkg::ARL_T_4_20MA;
    return res;
  endfunction

  // Field address of analog output a
  function automatic logic [7:0] ao_addr(input int a, input logic [7:0] ofs);
    logic [7:0] res;
    res = arl_pkg::REG_AO_BASE + ofs;
    if (a != 0)
      res = res + arl_pkg::AO_STRIDE;
    return res;
  endfunction

  // Allocation word of relay r
  function automatic logic [7:0] alloc_addr(input int r);
    logic [7:0] res;
    res = arl_pkg::REG_ALLOC0;
    for (int i = 0; i < r; i++)
      res = res + arl_pkg::REG_STRIDE;
    return res;
  endfunction

  // ----------------------------------------
  // Outputs straight from flops
  // ----------------------------------------
  assign reg_rdata = r_ff.rdata;
  assign irq = r_ff.irq;
  assign relay_drive = r_ff.relay;
  assign retransmit_type_select_1 = r_ff.ao_type[0];
  assign retransmit_type_select_2 = r_ff.ao_type[1];
  assign ao_code_1 = code_1;
  assign ao_code_2 = code_2;

  // ----------------------------------------
  // Scalers
  // ----------------------------------------
  // Both scalers see the same value
  arl_scale u_scale_1
  (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .value(disp_value),
    .lo(r_ff.ao_lo[0]),
    .hi(r_ff.ao_hi[0]),
    .code(code_1)
  );

  // Second output only exists with the dual option
  generate
    if (DUAL_FITTED)
    begin : g_dual
      arl_scale u_scale_2
      (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .value(disp_value),
        .lo(r_ff.ao_lo[1]),
        .hi(r_ff.ao_hi[1]),
        .code(code_2)
      );
    end
    else
    begin : g_single
      // Code parked at the bottom of range
      assign code_2 = arl_pkg::CODE_MIN;
    end
  endgenerate

  // ----------------------------------------
  // Next-state logic
  // ----------------------------------------
  always_comb
  begin
    nxt_r = r_ff;
    act = 7'h00;
    // Pins pass two flops; edges are taken from the second only
    nxt_r.pin_s1 = {ack_remote_pin, ack_alt_pin, ack_front_pin};
    nxt_r.pin_s2 = r_ff.pin_s1;
    nxt_r.pin_prev = r_ff.pin_s2;
    pin_rise = r_ff.pin_s2 & ~r_ff.pin_prev;
    // Front button always counts; the others by configuration
    ack_evt = pin_rise[0]
      | (pin_rise[1] & r_ff.ack_src[0])
      | (pin_rise[2] & r_ff.ack_src[1]);
    // A register pulse acts as a front press
    if (reg_wr && reg_addr == arl_pkg::REG_CTRL && reg_wdata[arl_pkg::CTRL_ACK_BIT])
      ack_evt = 1'b1;

    // Relay combining, acknowledge and polarity
    for (int r = 0; r < arl_pkg::NUM_RELAY; r++)
    begin
      // Hysteresis and delays are already in alarm_active
      act[r] = combine(r_ff.alloc[r], alarm_active, r_ff.and_mode[r]);
      // Hold drops once the alarm clears, whatever the latch mode
      if (!act[r])
        nxt_r.hold[r] = 1'b0;
      else if (ack_evt && r_ff.ack_en[r])
        nxt_r.hold[r] = 1'b1;
      nxt_r.relay[r] = r_ff.pol[r] ^ (act[r] & ~nxt_r.hold[r]);
    end
    // For edge detect and status
    nxt_r.act_prev = act;

    // Register writes
    if (reg_wr)
    begin
      unique case (reg_addr)
        // Bit 0 is a pulse, never stored
        arl_pkg::REG_CTRL:
          nxt_r.ack_src = reg_wdata[arl_pkg::CTRL_SRC_LSB +: 2];
        arl_pkg::REG_POL:
          nxt_r.pol = reg_wdata[6:0];
        arl_pkg::REG_ACK_EN:
          nxt_r.ack_en = reg_wdata[6:0];
        arl_pkg::REG_MODE:
          nxt_r.and_mode = reg_wdata[6:0];
        // Interrupt clear falls to default
        arl_pkg::REG_INT_EN:
          nxt_r.int_en = reg_wdata[7:0];
        // Allocation and analog settings
        default:
        begin
          for (int r = 0; r < arl_pkg::NUM_RELAY; r++)
          begin
            if (reg_addr == alloc_addr(r))
              nxt_r.alloc[r] = reg_wdata[7:0];
          end
          for (int a = 0; a < arl_pkg::NUM_AO; a++)
          begin
            if (a == 0 || DUAL_FITTED)
            begin
              if (reg_addr == ao_addr(a, arl_pkg::AO_TYPE_OFS))
                nxt_r.ao_type[a] = fix_type(reg_wdata[1:0]);
              if (reg_addr == ao_addr(a, arl_pkg::AO_LO_OFS))
                nxt_r.ao_lo[a] = reg_wdata;
              if (reg_addr == ao_addr(a, arl_pkg::AO_HI_OFS))
                nxt_r.ao_hi[a] = reg_wdata;
            end
          end
        end
      endcase
    end

    // Sticky events: clear first, so a same-cycle set wins
    if (reg_wr && reg_addr == arl_pkg::REG_INT_CLR)
      nxt_r.int_stat = r_ff.int_stat & ~reg_wdata[7:0];
    nxt_r.int_stat[6:0] = nxt_r.int_stat[6:0] | (act & ~r_ff.act_prev);
    if (ack_evt)
      nxt_r.int_stat[arl_pkg::INT_ACK_BIT] = 1'b1;
    // Enable gates the line, not the status
    nxt_r.irq = |(nxt_r.int_stat & nxt_r.int_en);

    // Register reads, data in the following cycle only
    nxt_r.rdata = 32'h00000000;
    if (reg_rd)
    begin
      unique case (reg_addr)
        // Pulse bit reads as zero
        arl_pkg::REG_CTRL:
          nxt_r.rdata[arl_pkg::CTRL_SRC_LSB +: 2] = r_ff.ack_src;
        arl_pkg::REG_POL:
          nxt_r.rdata[6:0] = r_ff.pol;
        arl_pkg::REG_ACK_EN:
          nxt_r.rdata[6:0] = r_ff.ack_en;
        arl_pkg::REG_MODE:
          nxt_r.rdata[6:0] = r_ff.and_mode;
        // Live state and build options
        arl_pkg::REG_STATUS:
        begin
          nxt_r.rdata[6:0] = r_ff.relay;
          nxt_r.rdata[arl_pkg::STAT_ACT_LSB +: 7] = r_ff.act_prev;
          nxt_r.rdata[arl_pkg::STAT_HOLD_LSB +: 7] = r_ff.hold;
          nxt_r.rdata[arl_pkg::STAT_CHOICE_BIT] = CHOICE_FITTED;
          nxt_r.rdata[arl_pkg::STAT_DUAL_BIT] = DUAL_FITTED;
        end
        arl_pkg::REG_INT_STAT:
          nxt_r.rdata[7:0] = r_ff.int_stat;
        arl_pkg::REG_INT_EN:
          nxt_r.rdata[7:0] = r_ff.int_en;
        // Clear register reads as zero
        default:
        begin
          for (int r = 0; r < arl_pkg::NUM_RELAY; r++)
          begin
            if (reg_addr == alloc_addr(r))
              nxt_r.rdata[7:0] = r_ff.alloc[r];
          end
          // Absent second output reads as zero
          for (int a = 0; a < arl_pkg::NUM_AO; a++)
          begin
            if (a == 0 || DUAL_FITTED)
            begin
              if (reg_addr == ao_addr(a, arl_pkg::AO_TYPE_OFS))
                nxt_r.rdata[1:0] = r_ff.ao_type[a];
              if (reg_addr == ao_addr(a, arl_pkg::AO_LO_OFS))
                nxt_r.rdata = r_ff.ao_lo[a];
              if (reg_addr == ao_addr(a, arl_pkg::AO_HI_OFS))
                nxt_r.rdata = r_ff.ao_hi[a];
            end
          end
        end
      endcase
    end
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      // Normally open, OR mode, nothing allocated
      r_ff.pol <= 7'h00;
      r_ff.ack_en <= 7'h00;
      r_ff.and_mode <= 7'h00;
      r_ff.alloc <= 56'h00000000000000;
      r_ff.ack_src <= 2'h0;
      // Both outputs 4-20 mA over 0 to 1000
      r_ff.ao_type <= {arl_pkg::ARL_T_4_20MA, arl_pkg::ARL_T_4_20MA};
      r_ff.ao_lo <= {arl_pkg::AO_LO_RST, arl_pkg::AO_LO_RST};
      r_ff.ao_hi <= {arl_pkg::AO_HI_RST, arl_pkg::AO_HI_RST};
      // Runtime state
      r_ff.hold <= 7'h00;
      r_ff.act_prev <= 7'h00;
      r_ff.relay <= 7'h00;
      r_ff.int_stat <= 8'h00;
      r_ff.int_en <= 8'h00;
      r_ff.irq <= 1'b0;
      r_ff.rdata <= 32'h00000000;
      r_ff.pin_s1 <= 3'h0;
      r_ff.pin_s2 <= 3'h0;
      r_ff.pin_prev <= 3'h0;
    end
    else
      r_ff <= nxt_r;
  end
endmodule
`default_nettype wire

/* verilog/arl_pkg.sv */
// Constants, register map and types for the alarm relay output block.
// Assumes a 32-bit register port with byte addresses on word boundaries.
`default_nettype none
package arl_pkg;
  // ----------------------------------------
  // Sizes
  // ----------------------------------------
  localparam int NUM_RELAY = 7;
  localparam int NUM_ALARM = 8;
  localparam int NUM_AO = 2;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int VAL_W = 32;
  localparam int CODE_W = 16;
  localparam int NUM_W = 48;
  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_POL = 8'h04;
  localparam logic [7:0] REG_ACK_EN = 8'h08;
  localparam logic [7:0] REG_MODE = 8'h0C;
  localparam logic [7:0] REG_ALLOC0 = 8'h10;
  localparam logic [7:0] REG_STRIDE = 8'h04;
  localparam logic [7:0] REG_AO_BASE = 8'h2C;
  localparam logic [7:0] AO_STRIDE = 8'h0C;
  localparam logic [7:0] AO_TYPE_OFS = 8'h00;
  localparam logic [7:0] AO_LO_OFS = 8'h04;
  localparam logic [7:0] AO_HI_OFS = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h44;
  localparam logic [7:0] REG_INT_STAT = 8'h48;
  localparam logic [7:0] REG_INT_CLR = 8'h4C;
  localparam logic [7:0] REG_INT_EN = 8'h50;
  // ----------------------------------------
  // Field positions and reset values
  // ----------------------------------------
  localparam int CTRL_ACK_BIT = 0;
  localparam int CTRL_SRC_LSB = 1;
  localparam int STAT_ACT_LSB = 8;
  localparam int STAT_HOLD_LSB = 16;
  localparam int STAT_CHOICE_BIT = 24;
  localparam int STAT_DUAL_BIT = 25;
  localparam int INT_ACK_BIT = 7;
  localparam logic [31:0] AO_LO_RST = 32'h00000000;
  localparam logic [31:0] AO_HI_RST = 32'h000003E8;
  localparam logic [15:0] CODE_MAX = 16'hFFFF;
  localparam logic [15:0] CODE_MIN = 16'h0000;
  localparam logic [4:0] DIV_LAST = 5'h0F;
  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [1:0] {
    ARL_T_4_20MA = 2'b00,
    ARL_T_0_1V = 2'b01,
    ARL_T_0_10V = 2'b10
  } arl_otype_t;
  typedef enum logic {
    ARL_S_LOAD = 1'b0,
    ARL_S_DIV = 1'b1
  } arl_sstate_t;
endpackage
`default_nettype wire

/* verilog/arl_scale.sv */
// Linear scaler: display value to 16-bit retransmission code.
// Assumes value, lo and hi are signed words on the same clock.
`timescale 1ns/1ps
`default_nettype none
module arl_scale
(
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic [31:0] value,
  input wire logic [31:0] lo,
  input wire logic [31:0] hi,
  output logic [15:0] code
);
  typedef struct packed {
    arl_pkg::arl_sstate_t st;
    logic [47:0] rem;
    logic [47:0] dsh;
    logic [15:0] q;
    logic [4:0] step;
    logic [15:0] code;
  } arl_scale_t;

  arl_scale_t r_ff;
  arl_scale_t nxt_r;
  logic [32:0] span;
  logic [32:0] ofs;

  assign code = r_ff.code;

  // ----------------------------------------
  // Clamp or start a 16-step divide
  // ----------------------------------------
  always_comb
  begin
    nxt_r = r_ff;
    span = {hi[31], hi} - {lo[31], lo};
    ofs = {value[31], value} - {lo[31], lo};
    unique case (r_ff.st)
      arl_pkg::ARL_S_LOAD:
      begin
        if ($signed(value) >= $signed(hi))
          nxt_r.code = arl_pkg::CODE_MAX;
        else if ($signed(value) <= $signed(lo))
          nxt_r.code = arl_pkg::CODE_MIN;
        else
        begin
          // Numerator is ofs*65535 so the top code equals hi
          nxt_r.rem = {ofs[31:0], 16'h0000} - {16'h0000, ofs[31:0]};
          nxt_r.dsh = {1'b0, span[31:0], 15'h0000};
          nxt_r.q = 16'h0000;
          nxt_r.step = 5'h00;
          nxt_r.st = arl_pkg::ARL_S_DIV;
        end
      end
      arl_pkg::ARL_S_DIV:
      begin
        if (r_ff.rem >= r_ff.dsh)
        begin
          nxt_r.rem = r_ff.rem - r_ff.dsh;
          nxt_r.q = {r_ff.q[14:0], 1'b1};
        end
        else
          nxt_r.q = {r_ff.q[14:0], 1'b0};
        nxt_r.dsh = {1'b0, r_ff.dsh[47:1]};
        nxt_r.step = r_ff.step + 5'h01;
        if (r_ff.step == arl_pkg::DIV_LAST)
        begin
          nxt_r.code = nxt_r.q;
          nxt_r.st = arl_pkg::ARL_S_LOAD;
        end
      end
    endcase
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      r_ff.st <= arl_pkg::ARL_S_LOAD;
      r_ff.rem <= 48'h000000000000;
      r_ff.dsh <= 48'h000000000000;
      r_ff.q <= 16'h0000;
      r_ff.step <= 5'h00;
      r_ff.code <= 16'h0000;
    end
    else
      r_ff <= nxt_r;
  end
endmodule
`default_nettype wire

/* dv/arl_relay_out_props.sv */
// Concurrent checks on the ports of the alarm relay output block.
// Assumes AO1 low and high change only through register writes.
`timescale 1ns/1ps
`default_nettype none
module arl_relay_out_props
#(
  parameter bit CHOICE_FITTED = 1'b1,
  parameter bit DUAL_FITTED = 1'b1
)
(
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic [7:0] alarm_active,
  input wire logic [31:0] disp_value,
  input wire logic ack_front_pin,
  input wire logic ack_alt_pin,
  input wire logic ack_remote_pin,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic irq,
  input wire logic [6:0] relay_drive,
  input wire logic [15:0] ao_code_1,
  input wire logic [15:0] ao_code_2,
  input wire logic [1:0] retransmit_type_select_1,
  input wire logic [1:0] retransmit_type_select_2
);
  // --------
  // Helper logic
  // --------
  logic [31:0] lo_ff;
  logic [31:0] hi_ff;
  logic [5:0] sc_ff;
  logic [2:0] qc_ff;
  logic [15:0] exp_code;
  longint d;
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!resetn);
  // AO1 scaling shadow; counters of quiet cycles since the last cause
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      lo_ff <= arl_pkg::AO_LO_RST;
      hi_ff <= arl_pkg::AO_HI_RST;
      sc_ff <= 6'h00;
      qc_ff <= 3'h0;
    end
    else
    begin
      if (reg_wr && reg_addr == 8'h30) lo_ff <= reg_wdata;
      if (reg_wr && reg_addr == 8'h34) hi_ff <= reg_wdata;
      sc_ff <= (reg_wr || $changed(disp_value)) ? 6'h00 : sc_ff + {5'h00, sc_ff != 6'h3F};
      qc_ff <= (reg_wr || $changed({alarm_active, ack_front_pin, ack_alt_pin, ack_remote_pin})) ? 3'h0 :
        qc_ff + {2'h0, qc_ff != 3'h7};
    end
  end
  // Clamped linear code; no division when high equals low
  always_comb
  begin
    d = longint'($signed(disp_value)) - longint'($signed(lo_ff));
    if ($signed(disp_value) >= $signed(hi_ff)) exp_code = 16'hFFFF;
    else if ($signed(disp_value) <= $signed(lo_ff)) exp_code = 16'h0000;
    else exp_code = 16'((d * 64'shFFFF) / (longint'($signed(hi_ff)) - longint'($signed(lo_ff))));
  end
  // --------
  // Assertions
  // --------
  rdata_idle_a:
    assert property (!$past(reg_rd) |-> reg_rdata == 32'h0000_0000) else $error("read data outside read slot");
  reset_zero_a:
    assert property (disable iff (1'b0) !resetn |-> relay_drive == 7'h00 && ao_code_1 == 16'h0000 &&
      retransmit_type_select_1 == 2'b00) else $error("outputs not idle in reset");
  type_legal_a:
    assert property (retransmit_type_select_1 != 2'b11 && retransmit_type_select_2 != 2'b11) else $error("bad type");
  type_write_a:
    assert property ($changed(retransmit_type_select_1) |-> reg_wr || $past(reg_wr)) else $error("type moved alone");
  relay_quiet_a:
    assert property (qc_ff == 3'h7 && !reg_wr && $stable(alarm_active) |-> $stable(relay_drive))
      else $error("relay moved without cause");
  code_top_a:
    assert property (sc_ff >= 6'h28 && $stable(disp_value) && exp_code == 16'hFFFF |-> ao_code_1 == 16'hFFFF)
      else $error("code not at top");
  code_bot_a:
    assert property (sc_ff >= 6'h28 && $stable(disp_value) && exp_code == 16'h0000 |-> ao_code_1 == 16'h0000)
      else $error("code not at bottom");
  code_lin_a:
    assert property (sc_ff >= 6'h28 && $stable(disp_value) |-> ao_code_1 == exp_code) else $error("code not linear");
  irq_fall_a:
    assert property ($fell(irq) |-> reg_wr || $past(reg_wr)) else $error("irq dropped without write");
  cover property (relay_drive != 7'h00);
  cover property (ao_code_1 == 16'hFFFF);
  cover property ($rose(irq));
endmodule
`default_nettype wire

/* dv/arl_out_stage.sv */
// Model of the relay drivers and one analog retransmission stage.
// Assumes codes and types come straight from the block's registered outputs.
`timescale 1ns/1ps
`default_nettype none
module arl_out_stage
(
  input wire logic [6:0] relay_drive,
  input wire logic [15:0] code,
  input wire logic [1:0] otype,
  output logic [6:0] contact_closed,
  output var int level
);
  // --------
  // Far side behaviour
  // --------
  // Energised coil closes the contact
  assign contact_closed = relay_drive;
  // Level in uA or mV; an unknown type shows a value no range can give
  always_comb
  begin
    case (otype)
      2'b00: level = 32'hFA0 + int'((longint'(code) * 64'sh3E80) / 64'shFFFF);
      2'b01: level = int'((longint'(code) * 64'sh3E8) / 64'shFFFF);
      2'b10: level = int'((longint'(code) * 64'sh2710) / 64'shFFFF);
      default: level = -1;
    endcase
  end
endmodule
`default_nettype wire

/* dv/arl_relay_out_tb.sv */
// Self-checking bench for the alarm relay output block.
// Assumes one 20 MHz clock; the far-side model watches AO1 and the relays.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin err_total++; $display("Error %s exp %0h got %0h", n, e, g); end end
module arl_relay_out_tb;
  localparam logic [7:0] RA [12] = '{8'h04, 8'h08, 8'h0C, 8'h10, 8'h2C, 8'h30, 8'h34, 8'h38, 8'h3C, 8'h40, 8'h44, 8'hFC};
  localparam logic [31:0] RV [12] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h3E8, 32'h0, 32'h0, 32'h3E8,
    32'h0300_0000, 32'h0};
  logic ref_clk;
  logic resetn;
  logic [7:0] alarm_active;
  logic [31:0] disp_value;
  logic [2:0] pins;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [31:0] reg_rdata;
  logic irq;
  logic [6:0] relay_drive;
  logic [15:0] ao_code_1;
  logic [15:0] ao_code_2;
  logic [1:0] retransmit_type_select_1;
  logic [1:0] retransmit_type_select_2;
  logic [6:0] contact_closed;
  int level;
  int err_total = 0;
  int cmp_count = 0;
  int cyc = 0;
  logic [6:0] pol;
  logic [6:0] mode;
  logic [6:0] aen;
  logic [7:0] alloc [7];
  logic [31:0] rdv;
  int lo [2];
  int hi [2];
  int v;
  arl_relay_out u_arl_relay_out (.ref_clk(ref_clk), .resetn(resetn), .alarm_active(alarm_active),
    .disp_value(disp_value), .ack_front_pin(pins[0]), .ack_alt_pin(pins[1]), .ack_remote_pin(pins[2]),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .irq(irq), .relay_drive(relay_drive), .ao_code_1(ao_code_1), .ao_code_2(ao_code_2),
    .retransmit_type_select_1(retransmit_type_select_1), .retransmit_type_select_2(retransmit_type_select_2));
  arl_out_stage u_arl_out_stage (.relay_drive(relay_drive), .code(ao_code_1), .otype(retransmit_type_select_1),
    .contact_closed(contact_closed), .level(level));
  // --------
  // Clock, watchdog and bus tasks
  // --------
  initial
  begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  // Whole run needs about 950 cycles
  always @(posedge ref_clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      err_total++;
      conclude();
    end
  end
  task automatic conclude();
    if (err_total == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] dat);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= dat;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  // Data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] dat);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    @(negedge ref_clk);
    dat = reg_rdata;
  endtask
  // Source 0 is the second button while disabled, 4 the register
  task automatic press(input int s);
    if (s == 4) wr(8'h00, 32'h7);
    else
    begin
      @(posedge ref_clk);
      pins <= (s == 0) ? 3'b010 : 3'(1 << (s - 1));
      repeat (2) @(posedge ref_clk);
      pins <= 3'b000;
    end
    repeat (4) @(posedge ref_clk);
    #1;
  endtask
  function automatic logic [6:0] rel_exp(input logic [7:0] al);
    logic [6:0] c;
    for (int r = 0; r < 7; r++)
      c[r] = mode[r] ? (alloc[r] != 8'h00 && (al & alloc[r]) == alloc[r]) : |(al & alloc[r]);
    return pol ^ c;
  endfunction
  function automatic logic [15:0] scale_exp(input int x, input int l, input int h);
    if (x >= h) return 16'hFFFF;
    if (x <= l) return 16'h0000;
    return 16'((longint'(x - l) * 64'shFFFF) / (h - l));
  endfunction
  // --------
  // Main sequence
  // --------
  initial
  begin
    resetn = 1'b1;
    alarm_active = 8'h00;
    disp_value = 32'h0;
    pins = 3'b000;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    #1 resetn = 1'b0;
    void'($urandom(32'h93832312));
    repeat (5) @(posedge ref_clk);
    resetn <= 1'b1;
    // Reset values, then an unmapped place
    for (int i = 0; i < 12; i++)
    begin
      rd(RA[i], rdv);
      `CHK("reg reset", RV[i], rdv)
    end
    // Random polarity, mode and allocation; full and empty allocation forced
    pol = 7'($urandom);
    mode = 7'($urandom);
    wr(8'h04, {25'h0, pol});
    wr(8'h0C, {25'h0, mode});
    for (int r = 0; r < 7; r++)
    begin
      alloc[r] = (r == 0) ? 8'hFF : (r == 1) ? 8'h00 : 8'($urandom);
      wr(8'h10 + 8'(4 * r), {24'h0, alloc[r]});
    end
    for (int i = 0; i < 40; i++)
    begin
      @(posedge ref_clk);
      alarm_active <= (i < 2) ? {8{i[0]}} : 8'($urandom);
      repeat (2) @(posedge ref_clk);
      #1;
      `CHK("relay", rel_exp(alarm_active), contact_closed)
    end
    // Acknowledge from every source, then re-arm by clearing the alarm
    aen = 7'h55;
    wr(8'h08, {25'h0, aen});
    for (int s = 0; s < 5; s++)
    begin
      @(posedge ref_clk);
      alarm_active <= 8'hFF;
      repeat (3) @(posedge ref_clk);
      #1;
      `CHK("rearm", rel_exp(8'hFF), contact_closed)
      if (s == 1) wr(8'h00, 32'h6);
      press(s);
      `CHK("ack", pol ^ ((rel_exp(8'hFF) ^ pol) & ((s == 0) ? 7'h7F : ~aen)), contact_closed)
      @(posedge ref_clk);
      alarm_active <= 8'h00;
    end
    // Ack event raises, masks and clears the interrupt
    wr(8'h50, 32'h80);
    wr(8'h4C, 32'hFF);
    repeat (2) @(posedge ref_clk);
    `CHK("irq idle", 1'b0, irq)
    press(4);
    `CHK("irq set", 1'b1, irq)
    rd(8'h48, rdv);
    `CHK("ack flag", 1'b1, rdv[7])
    wr(8'h50, 32'h0);
    repeat (2) @(posedge ref_clk);
    `CHK("irq masked", 1'b0, irq)
    wr(8'h50, 32'h80);
    repeat (2) @(posedge ref_clk);
    `CHK("irq unmasked", 1'b1, irq)
    wr(8'h4C, 32'h80);
    repeat (2) @(posedge ref_clk);
    `CHK("irq cleared", 1'b0, irq)
    // Both outputs scaled with their own ranges; edges and clamps of AO1 first
    for (int i = 0; i < 8; i++)
    begin
      for (int k = 0; k < 2; k++)
      begin
        lo[k] = int'($urandom_range(2000)) - 1000;
        hi[k] = lo[k] + int'($urandom_range(4000)) + 1;
        wr(8'h30 + 8'(12 * k), 32'(lo[k]));
        wr(8'h34 + 8'(12 * k), 32'(hi[k]));
      end
      v = (i == 0) ? lo[0] : (i == 1) ? hi[0] : (i == 2) ? lo[0] - 1 :
        lo[0] - 100 + int'($urandom_range(hi[0] - lo[0] + 200));
      @(posedge ref_clk);
      disp_value <= 32'(v);
      repeat (45) @(posedge ref_clk);
      `CHK("code 1", scale_exp(v, lo[0], hi[0]), ao_code_1)
      `CHK("code 2", scale_exp(v, lo[1], hi[1]), ao_code_2)
    end
    // Every type code, the unused one included, at the top of the range
    @(posedge ref_clk);
    disp_value <= 32'h0010_0000;
    for (int t = 0; t < 4; t++)
    begin
      wr(8'h2C, 32'(t));
      wr(8'h38, 32'(3 - t));
      repeat (45) @(posedge ref_clk);
      `CHK("type 1", 2'((t == 3) ? 0 : t), retransmit_type_select_1)
      `CHK("type 2", 2'((t == 0) ? 0 : 3 - t), retransmit_type_select_2)
      `CHK("top level", (t == 1) ? 32'h3E8 : (t == 2) ? 32'h2710 : 32'h4E20, level)
    end
    @(posedge ref_clk);
    disp_value <= 32'h8000_0000;
    repeat (45) @(posedge ref_clk);
    `CHK("bottom level", 32'hFA0, level)
    conclude();
  end
endmodule
bind arl_relay_out arl_relay_out_props #(.CHOICE_FITTED(CHOICE_FITTED), .DUAL_FITTED(DUAL_FITTED)) u_props (
  .ref_clk(ref_clk), .resetn(resetn), .alarm_active(alarm_active), .disp_value(disp_value),
  .ack_front_pin(ack_front_pin), .ack_alt_pin(ack_alt_pin), .ack_remote_pin(ack_remote_pin),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .irq(irq), .relay_drive(relay_drive), .ao_code_1(ao_code_1), .ao_code_2(ao_code_2),
  .retransmit_type_select_1(retransmit_type_select_1), .retransmit_type_select_2(retransmit_type_select_2));
`default_nettype wire
